// >>> logic/sarq_pkg.sv
// Constants, register layout and source codes of the converter sequencer.
// Operation
// [RULE1] Result loaded, done flag set per conversion
// [RULE2] Control write aborts, clears flag, restarts
// [RULE3] Reset clears clock select and power
// [RULE4] Conversion lasts 32 conversion clock cycles
// [RULE5] Conversions repeat until control rewritten
// [RULE6] New result overwrites, no overrun kept
// [RULE7] Reading result clears the done flag
// [RULE8] Clock select picks RC oscillator ticks
// [RULE9] Software picks RC below 1 MHz bus
// [RULE10] RC results pass through bus synchroniser
// [RULE11] Software polls done flag in RC mode
// [RULE12] Power bit enables charge pump, sources
// [RULE13] Oscillator may run while converter off
// [RULE14] Software writes zero to test bit
// [RULE15] Four bit channel select, sixteen inputs
// [RULE16] Channel to source mapping per table
// [RULE17] Full scale gives all ones, bottom zeros
// [RULE18] WAIT mode changes nothing, flag kept
// [RULE19] Software clears bits before WAIT if idle
// [RULE20] Each reference routed internal or external
// [RULE21] STOP aborts conversion, pump off
// [RULE22] STOP leaves registers unchanged
// [RULE23] Sample switch closed at most 12 cycles
// [RULE24] Bits decided MSB first within conversion
// [RULE25] Powered off sequencer stays idle
package sarq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SARQ_IDX_RESULT = 8'h0E;
  localparam logic [7:0] SARQ_IDX_CTRL = 8'h0F;
  localparam logic [7:0] SARQ_IDX_REF = 8'h10;
  localparam logic [7:0] SARQ_ADDR_RESULT = 8'h38;
  localparam logic [7:0] SARQ_ADDR_CTRL = 8'h3C;
  localparam logic [7:0] SARQ_ADDR_REF = 8'h40;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int SARQ_CTRL_DONE = 7;
  localparam int SARQ_CTRL_RCSEL = 6;
  localparam int SARQ_CTRL_PWR = 5;
  localparam int SARQ_CTRL_TEST = 4;
  localparam int SARQ_CTRL_CH_LSB = 0;
  localparam int SARQ_REF_UPPER_EXT = 0;
  localparam int SARQ_REF_LOWER_EXT = 1;
  localparam logic [7:0] SARQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] SARQ_RESULT_RESET = 8'h00;
  localparam logic [1:0] SARQ_REF_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SARQ_CLK_MHZ = 100;
  localparam logic [4:0] SARQ_CONV_LAST_TICK = 5'h1F;
  localparam logic [4:0] SARQ_SAMPLE_TICKS = 5'h04;
  localparam int SARQ_SAMPLE_MAX_BUS_CYC = 12;
  localparam logic [3:0] SARQ_SAMPLE_MAX = 4'(SARQ_SAMPLE_MAX_BUS_CYC);

  // ----------------------------------------------------------------
  // Multiplexer source kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SARQ_SRC_TEMP,
    SARQ_SRC_PIN,
    SARQ_SRC_SUPPLY,
    SARQ_SRC_UPPER,
    SARQ_SRC_MID,
    SARQ_SRC_LOWER
  } sarq_src_e;

endpackage

// >>> logic/sarq_top.sv
// Successive-approximation converter sequencer with APB register slave.
`timescale 1ns/1ps
module sarq_top
  import sarq_pkg::*;
(
  // Clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // System mode
  input wire logic STOP_MODE,
  // Analog front end
  input wire logic RC_OSC_CLK,
  input wire logic COMP_ABOVE,
  output logic RC_OSC_EN,
  output logic CHARGE_PUMP_EN,
  output logic SAMPLE_CLOSE,
  output logic [7:0] DAC_CODE,
  output logic [3:0] MUX_CHANNEL,
  output logic [2:0] MUX_SOURCE,
  output logic [5:0] MUX_PIN_EN,
  output logic REF_UPPER_EXT,
  output logic REF_LOWER_EXT,
  output logic TEST_MODE
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Keeps the trial bit when the held input is above the DAC level.
  function automatic logic [7:0] sar_decide(input logic [7:0] trial, input logic [7:0] bitmask,
                                            input logic above);
    sar_decide = above ? trial : (trial & ~bitmask);
  endfunction

  function automatic sarq_src_e chan_source(input logic [3:0] ch);
    sarq_src_e src;
    src = SARQ_SRC_LOWER;
    unique case (ch)
      4'h0: src = SARQ_SRC_TEMP;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: src = SARQ_SRC_PIN;
      4'h7: src = SARQ_SRC_SUPPLY;
      4'h8: src = SARQ_SRC_UPPER;
      4'h9: src = SARQ_SRC_MID;
      4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: src = SARQ_SRC_LOWER;
    endcase
    chan_source = src;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rcsel_q;
  logic pwr_q;
  logic test_q;
  logic [3:0] chan_q;
  logic done_q;
  logic done_d;
  logic [7:0] result_q;
  logic [1:0] ref_q;
  logic [2:0] rc_sync_q;
  logic rc_lvl_q;
  logic [2:0] cmp_sync_q;
  logic cmp_lvl_q;
  logic cmp_now;
  logic tick;
  logic running;
  logic [4:0] tick_cnt_q;
  logic pending_q;
  logic [7:0] sar_q;
  logic [7:0] mask_q;
  logic [3:0] samp_cnt_q;
  logic apb_setup;
  logic apb_access;
  logic addr_ok;
  logic ctrl_wr;
  logic ref_wr;
  logic result_rd;
  logic conv_end;
  logic [7:0] rd_mux;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_access = PSEL & PENABLE;
  assign addr_ok = (PADDR == SARQ_ADDR_RESULT) | (PADDR == SARQ_ADDR_CTRL) | (PADDR == SARQ_ADDR_REF);
  assign ctrl_wr = CLK_EN & apb_access & PWRITE & (PADDR == SARQ_ADDR_CTRL);
  assign ref_wr = CLK_EN & apb_access & PWRITE & (PADDR == SARQ_ADDR_REF);
  assign result_rd = CLK_EN & apb_access & ~PWRITE & (PADDR == SARQ_ADDR_RESULT);

  // Zero wait states; a stalled CLK_EN also stalls the transfer.
  assign PREADY = CLK_EN;
  assign PSLVERR = apb_access & ~addr_ok;

  always_comb begin
    rd_mux = 8'h00;
    if (PADDR == SARQ_ADDR_RESULT) begin
      rd_mux = result_q;
    end else if (PADDR == SARQ_ADDR_CTRL) begin
      rd_mux = {done_q, rcsel_q, pwr_q, test_q, chan_q};
    end else if (PADDR == SARQ_ADDR_REF) begin
      rd_mux = {6'h00, ref_q};
    end
  end

  // Read data is captured in the setup cycle so that it comes from a flip-flop.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN && apb_setup && !PWRITE) begin
      PRDATA <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // Control and reference registers
  // ----------------------------------------------------------------
  // STOP_MODE has no effect here, so the settings survive STOP. [RULE22]
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rcsel_q <= SARQ_CTRL_RESET[SARQ_CTRL_RCSEL]; // [RULE3]
      pwr_q <= SARQ_CTRL_RESET[SARQ_CTRL_PWR]; // [RULE3]
      test_q <= SARQ_CTRL_RESET[SARQ_CTRL_TEST];
      chan_q <= SARQ_CTRL_RESET[SARQ_CTRL_CH_LSB +: 4];
    end else if (ctrl_wr) begin
      rcsel_q <= PWDATA[SARQ_CTRL_RCSEL];
      pwr_q <= PWDATA[SARQ_CTRL_PWR];
      test_q <= PWDATA[SARQ_CTRL_TEST];
      chan_q <= PWDATA[SARQ_CTRL_CH_LSB +: 4]; // [RULE15]
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_q <= SARQ_REF_RESET;
    end else if (ref_wr) begin
      ref_q <= {PWDATA[SARQ_REF_LOWER_EXT], PWDATA[SARQ_REF_UPPER_EXT]}; // [RULE20]
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock and comparator synchronisers
  // ----------------------------------------------------------------
  // The RC clock is only sampled, so its period must exceed a few bus cycles.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rc_sync_q <= 3'h0;
      rc_lvl_q <= 1'b0;
      cmp_sync_q <= 3'h0;
      cmp_lvl_q <= 1'b0;
    end else if (CLK_EN) begin
      rc_sync_q <= {rc_sync_q[1:0], RC_OSC_CLK};
      cmp_sync_q <= {cmp_sync_q[1:0], COMP_ABOVE};
      if (rc_sync_q[1] == rc_sync_q[2]) begin
        rc_lvl_q <= rc_sync_q[2];
      end
      if (cmp_sync_q[1] == cmp_sync_q[2]) begin
        cmp_lvl_q <= cmp_sync_q[2];
      end
    end
  end

  // Each conversion step is a bus-clock tick, or a synchronised RC rising edge when RC is selected, so RC results land synchronously. [RULE8] [RULE10]
  assign tick = rcsel_q ? ((rc_sync_q[1] == rc_sync_q[2]) & rc_sync_q[2] & ~rc_lvl_q) : 1'b1;
  assign cmp_now = (cmp_sync_q[1] == cmp_sync_q[2]) ? cmp_sync_q[2] : cmp_lvl_q;
  assign running = pwr_q & ~STOP_MODE; // [RULE25] [RULE21]

  // ----------------------------------------------------------------
  // Successive-approximation sequencer
  // ----------------------------------------------------------------
  // A trial bit is set every fourth tick and judged four ticks later, which covers
  // the comparator synchroniser. The last bit is judged at tick 0 of the next period,
  // so a result appears every 32 ticks. [RULE4] [RULE24]
  // DAC_CODE is loaded together with the trial register, not one cycle after it, because
  // the extra cycle would leave the synchroniser one stage short at the judging tick.
  assign conv_end = CLK_EN & running & tick & pending_q & (tick_cnt_q == 5'h00) & ~ctrl_wr;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_q <= 5'h00;
      pending_q <= 1'b0;
      sar_q <= 8'h00;
      mask_q <= 8'h00;
      DAC_CODE <= 8'h00;
    end else if (CLK_EN) begin
      if (ctrl_wr || !running) begin
        tick_cnt_q <= 5'h00; // [RULE2] [RULE21] [RULE25]
        pending_q <= 1'b0;
      end else if (tick) begin
        tick_cnt_q <= (tick_cnt_q == SARQ_CONV_LAST_TICK) ? 5'h00 : tick_cnt_q + 5'h01; // [RULE5]
        if (tick_cnt_q == 5'h00) begin
          pending_q <= 1'b1;
          sar_q <= 8'h80;
          mask_q <= 8'h80;
          DAC_CODE <= 8'h80;
        end else if (tick_cnt_q[1:0] == 2'h0) begin
          sar_q <= sar_decide(sar_q, mask_q, cmp_now) | (mask_q >> 1); // [RULE24]
          DAC_CODE <= sar_decide(sar_q, mask_q, cmp_now) | (mask_q >> 1);
          mask_q <= mask_q >> 1;
        end
      end
    end
  end

  // Sample switch closes at the start only and never stays past 12 bus cycles.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      samp_cnt_q <= 4'h0;
    end else if (CLK_EN) begin
      if (ctrl_wr || !running || (tick && tick_cnt_q == 5'h00)) begin
        samp_cnt_q <= 4'h0;
      end else if (samp_cnt_q != SARQ_SAMPLE_MAX) begin
        samp_cnt_q <= samp_cnt_q + 4'h1; // [RULE23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Result and completion flag
  // ----------------------------------------------------------------
  // Full scale leaves every trial bit kept, giving all ones; zero input clears all. [RULE17]
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      result_q <= SARQ_RESULT_RESET;
    end else if (conv_end) begin
      result_q <= sar_decide(sar_q, mask_q, cmp_now); // [RULE1] [RULE6]
    end
  end

  // A finishing conversion wins over a read clear; a control write aborts it first.
  // Nothing else clears the flag, so WAIT has no effect on it. [RULE18]
  always_comb begin
    done_d = done_q;
    if (ctrl_wr) begin
      done_d = 1'b0; // [RULE2]
    end else if (conv_end) begin
      done_d = 1'b1; // [RULE1] [RULE5]
    end else if (result_rd) begin
      done_d = 1'b0; // [RULE7]
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      done_q <= SARQ_CTRL_RESET[SARQ_CTRL_DONE];
    end else begin
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RC_OSC_EN <= 1'b0;
      CHARGE_PUMP_EN <= 1'b0;
      SAMPLE_CLOSE <= 1'b0;
      MUX_CHANNEL <= 4'h0;
      MUX_SOURCE <= SARQ_SRC_TEMP;
      MUX_PIN_EN <= 6'h00;
      REF_UPPER_EXT <= 1'b0;
      REF_LOWER_EXT <= 1'b0;
      TEST_MODE <= 1'b0;
    end else if (CLK_EN) begin
      RC_OSC_EN <= rcsel_q & ~STOP_MODE; // [RULE13]
      CHARGE_PUMP_EN <= running; // [RULE12] [RULE13] [RULE21]
      // Closing on the start tick itself lets the held input settle before the first judgement.
      SAMPLE_CLOSE <= running & ~ctrl_wr
                      & (tick ? (tick_cnt_q < SARQ_SAMPLE_TICKS - 5'h01)
                              : (tick_cnt_q != 5'h00 && tick_cnt_q < SARQ_SAMPLE_TICKS))
                      & ((tick && tick_cnt_q == 5'h00) || samp_cnt_q < SARQ_SAMPLE_MAX - 4'h1); // [RULE23]
      MUX_CHANNEL <= chan_q; // [RULE15]
      MUX_SOURCE <= chan_source(chan_q); // [RULE16]
      MUX_PIN_EN <= (chan_source(chan_q) == SARQ_SRC_PIN) ? 6'(6'h01 << (chan_q - 4'h1)) : 6'h00; // [RULE16]
      REF_UPPER_EXT <= ref_q[SARQ_REF_UPPER_EXT]; // [RULE20]
      REF_LOWER_EXT <= ref_q[SARQ_REF_LOWER_EXT]; // [RULE20]
      TEST_MODE <= test_q;
    end
  end

endmodule // sarq_top

// >>> bench/sarq_top_monitor.sv
// Concurrent checks on the converter sequencer ports.
`timescale 1ns/1ps
module sarq_top_monitor
  import sarq_pkg::*;
(
  // Clock, reset and bus
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  // Mode and front end
  input wire logic STOP_MODE,
  input wire logic RC_OSC_EN,
  input wire logic CHARGE_PUMP_EN,
  input wire logic SAMPLE_CLOSE,
  input wire logic [3:0] MUX_CHANNEL,
  input wire logic [2:0] MUX_SOURCE,
  input wire logic REF_UPPER_EXT,
  input wire logic REF_LOWER_EXT
);
  logic wr_c;
  logic wr_r;
  logic rose;
  logic smp_q;
  logic run_q;
  logic [5:0] gap_q;
  logic [3:0] hi_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  assign wr_c = PSEL && PENABLE && PWRITE && PADDR == SARQ_ADDR_CTRL;
  assign wr_r = PSEL && PENABLE && PWRITE && PADDR == SARQ_ADDR_REF;
  assign rose = SAMPLE_CLOSE && !smp_q;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      smp_q <= 1'b0;
      hi_q <= 4'h0;
    end else begin
      smp_q <= SAMPLE_CLOSE;
      hi_q <= !SAMPLE_CLOSE ? 4'h0 : hi_q + 4'(hi_q != 4'hF);
    end
  end
  // A sampling edge left over from an aborted conversion must not arm the period test.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_q <= 6'h00;
      run_q <= 1'b0;
    end else begin
      gap_q <= (wr_c || STOP_MODE) ? 6'h00 : rose ? 6'h01 : gap_q + 6'(gap_q != 6'h3F);
      run_q <= (wr_c || STOP_MODE || RC_OSC_EN || !CHARGE_PUMP_EN) ? 1'b0 : (rose && gap_q > 6'h03) ? 1'b1 : run_q;
    end
  end
  sequence s_ctrl_rd;
    PSEL && !PENABLE && !PWRITE && PADDR == SARQ_ADDR_CTRL;
  endsequence
  property p_period; $rose(SAMPLE_CLOSE) && run_q |-> gap_q == 6'd32; endproperty
  a_period: assert property (p_period) else $error("conversion period is not 32 cycles");
  property p_bound; run_q |-> gap_q <= 6'd32; endproperty
  a_bound: assert property (p_bound) else $error("conversion overran 32 cycles");
  property p_sample; hi_q <= 4'd12; endproperty
  a_sample: assert property (p_sample) else $error("sampling switch closed too long");
  property p_stop; STOP_MODE ##1 STOP_MODE |-> !CHARGE_PUMP_EN && !RC_OSC_EN; endproperty
  a_stop: assert property (p_stop) else $error("pump or oscillator on in stop");
  property p_pwr;
    wr_c ##1 !STOP_MODE |=> CHARGE_PUMP_EN == $past(PWDATA[SARQ_CTRL_PWR], 2)
      && RC_OSC_EN == $past(PWDATA[SARQ_CTRL_RCSEL], 2);
  endproperty
  a_pwr: assert property (p_pwr) else $error("enables do not follow control write");
  property p_clr; wr_c ##[1:2] s_ctrl_rd |=> !PRDATA[SARQ_CTRL_DONE]; endproperty
  a_clr: assert property (p_clr) else $error("done flag survived control write");
  property p_chan; wr_c |=> ##1 MUX_CHANNEL == $past(PWDATA[3:0], 2); endproperty
  a_chan: assert property (p_chan) else $error("channel does not follow write");
  property p_mux;
    MUX_SOURCE == (MUX_CHANNEL == 4'h0 ? SARQ_SRC_TEMP : MUX_CHANNEL < 4'h7 ? SARQ_SRC_PIN :
      MUX_CHANNEL == 4'h7 ? SARQ_SRC_SUPPLY : MUX_CHANNEL == 4'h8 ? SARQ_SRC_UPPER :
      MUX_CHANNEL == 4'h9 ? SARQ_SRC_MID : SARQ_SRC_LOWER);
  endproperty
  a_mux: assert property (p_mux) else $error("wrong source for channel");
  property p_ref;
    wr_r |=> ##1 REF_UPPER_EXT == $past(PWDATA[0], 2) && REF_LOWER_EXT == $past(PWDATA[1], 2);
  endproperty
  a_ref: assert property (p_ref) else $error("reference routing not applied");
endmodule // sarq_top_monitor

// >>> bench/sarq_afe_model.sv
// Behavioural comparator, sample-and-hold and RC oscillator.
`timescale 1ns/1ps
module sarq_afe_model (
  // Analog input and controls
  input wire logic [8:0] vin_x2,
  input wire logic SAMPLE_CLOSE,
  input wire logic RC_OSC_EN,
  input wire logic [7:0] DAC_CODE,
  // Answers
  output logic COMP_ABOVE,
  output logic RC_OSC_CLK
);
  logic [8:0] held_q = 9'h000;
  // Input is in half-code steps so the comparator never sees a tie.
  always @(SAMPLE_CLOSE or vin_x2) if (SAMPLE_CLOSE) held_q = vin_x2;
  assign COMP_ABOVE = held_q > {DAC_CODE, 1'b0};
  initial RC_OSC_CLK = 1'b0;
  // Stands still while disabled; 1.5 MHz when running.
  always #333 RC_OSC_CLK = RC_OSC_EN ? ~RC_OSC_CLK : 1'b0;
endmodule // sarq_afe_model

// >>> bench/tb_sarq_top.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module tb_sarq_top
  import sarq_pkg::*;
;
  logic CLK_SYS = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, STOP_MODE = 1'b0;
  logic CLK_EN = 1'b1;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [8:0] vin_x2 = 9'h000;
  logic [7:0] DAC_CODE;
  logic [3:0] MUX_CHANNEL;
  logic [2:0] MUX_SOURCE;
  logic [5:0] MUX_PIN_EN;
  logic PREADY, PSLVERR, slv, RC_OSC_CLK, COMP_ABOVE, RC_OSC_EN, CHARGE_PUMP_EN, SAMPLE_CLOSE;
  logic REF_UPPER_EXT, REF_LOWER_EXT, TEST_MODE;
  int errors = 0;
  int n_checks = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  sarq_top dut_u (.CLK_SYS, .ARST_N, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .STOP_MODE, .RC_OSC_CLK, .COMP_ABOVE, .RC_OSC_EN, .CHARGE_PUMP_EN, .SAMPLE_CLOSE,
    .DAC_CODE, .MUX_CHANNEL, .MUX_SOURCE, .MUX_PIN_EN, .REF_UPPER_EXT, .REF_LOWER_EXT, .TEST_MODE);
  sarq_afe_model afe_u (.vin_x2, .SAMPLE_CLOSE, .RC_OSC_EN, .DAC_CODE, .COMP_ABOVE, .RC_OSC_CLK);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
      n++;
    end while (rd[SARQ_CTRL_DONE] !== 1'b1 && n < lim);
    chk(32'(rd[SARQ_CTRL_DONE]), 32'h1);
  endtask
  task automatic t_regs();
    apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
    chk(rd, 32'(SARQ_CTRL_RESET));
    chk({30'h0, RC_OSC_EN, CHARGE_PUMP_EN}, 32'h0);
    apb(1'b1, SARQ_ADDR_RESULT, 32'h5A);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    chk(rd, 32'(SARQ_RESULT_RESET));
    apb(1'b0, 8'h80, 32'h0);
    chk({slv, rd[30:0]}, 32'h80000000);
    apb(1'b1, SARQ_ADDR_REF, 32'h3);
    apb(1'b0, SARQ_ADDR_REF, 32'h0);
    chk(rd, 32'h3);
    chk({30'h0, REF_LOWER_EXT, REF_UPPER_EXT}, 32'h3);
  endtask
  task automatic t_conv();
    vin_x2 <= 9'h14B;
    apb(1'b1, SARQ_ADDR_CTRL, 32'h23);
    wait_done(30);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    chk(rd, 32'hA5);
    apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
    chk(rd, 32'h23);
    chk({26'h0, MUX_PIN_EN}, 32'h4);
    vin_x2 <= 9'h1FF;
    wait_done(30);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    wait_done(30);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    chk(rd, 32'hFF);
    vin_x2 <= 9'h000;
    repeat (80) @(posedge CLK_SYS);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_abort();
    wait_done(30);
    apb(1'b1, SARQ_ADDR_CTRL, 32'h23);
    apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
    chk(rd, 32'h23);
    apb(1'b1, SARQ_ADDR_CTRL, 32'h0);
    repeat (80) @(posedge CLK_SYS);
    apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, RC_OSC_EN, CHARGE_PUMP_EN}, 32'h0);
    // A low clock enable must stall the bus answer.
    CLK_EN <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    chk({31'h0, PREADY}, 32'h0);
    CLK_EN <= 1'b1;
    @(posedge CLK_SYS);
  endtask
  task automatic t_chan();
    logic [2:0] s;
    for (int c = 0; c < 16; c++) begin
      s = c == 0 ? SARQ_SRC_TEMP : c < 7 ? SARQ_SRC_PIN : c == 7 ? SARQ_SRC_SUPPLY :
        c == 8 ? SARQ_SRC_UPPER : c == 9 ? SARQ_SRC_MID : SARQ_SRC_LOWER;
      apb(1'b1, SARQ_ADDR_CTRL, 32'h20 + c);
      @(posedge CLK_SYS);
      chk({28'h0, MUX_CHANNEL}, 32'(c));
      chk({29'h0, MUX_SOURCE}, {29'h0, s});
    end
  endtask
  task automatic t_rc();
    apb(1'b1, SARQ_ADDR_CTRL, 32'h40);
    @(posedge CLK_SYS);
    chk({30'h0, RC_OSC_EN, CHARGE_PUMP_EN}, 32'h2);
    vin_x2 <= 9'h079;
    apb(1'b1, SARQ_ADDR_CTRL, 32'h65);
    wait_done(1500);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    chk(rd, 32'h3C);
  endtask
  task automatic t_stop();
    apb(1'b1, SARQ_ADDR_CTRL, 32'h25);
    STOP_MODE <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    chk({30'h0, CHARGE_PUMP_EN, RC_OSC_EN}, 32'h0);
    apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
    chk(rd, 32'h25);
    apb(1'b0, SARQ_ADDR_RESULT, 32'h0);
    chk(rd, 32'h3C);
    STOP_MODE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic t_reset();
    apb(1'b1, SARQ_ADDR_CTRL, 32'h65);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    @(posedge CLK_SYS);
    apb(1'b0, SARQ_ADDR_CTRL, 32'h0);
    chk(rd, 32'(SARQ_CTRL_RESET));
    chk({30'h0, RC_OSC_EN, CHARGE_PUMP_EN}, 32'h0);
  endtask
  task automatic conclude();
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    @(posedge CLK_SYS);
    t_regs();
    t_conv();
    t_abort();
    t_chan();
    t_rc();
    t_stop();
    t_reset();
    conclude();
  end
  initial begin
    repeat (40000) @(posedge CLK_SYS);
    errors++;
    conclude();
  end
endmodule // tb_sarq_top
bind sarq_top sarq_top_monitor mon_u (.CLK_SYS, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
  .STOP_MODE, .RC_OSC_EN, .CHARGE_PUMP_EN, .SAMPLE_CLOSE, .MUX_CHANNEL, .MUX_SOURCE, .REF_UPPER_EXT,
  .REF_LOWER_EXT);
